// file: logic/flash_cmd_pkg.sv
`default_nettype none

package flash_cmd_pkg;

   // ==========================================================
   // Timing
   localparam int CLK_PERIOD_NS        = 40;
   localparam int WAKE_DELAY_FIRST_NS  = 3000;
   localparam int WAKE_DELAY_SECOND_NS = 5000;
   localparam int REG_WRITE_TIME_NS    = 10000000;

   // Least times round up to whole clock cycles
   function automatic int cycles_ceil(input int ns);
      return (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   endfunction : cycles_ceil

   localparam int WAKE_FIRST_CYCLES  = cycles_ceil(WAKE_DELAY_FIRST_NS);
   localparam int WAKE_SECOND_CYCLES = cycles_ceil(WAKE_DELAY_SECOND_NS);
   localparam int REG_WRITE_CYCLES   = cycles_ceil(REG_WRITE_TIME_NS);

   // ==========================================================
   // Opcodes and frame layout
   localparam logic [7:0] OP_ID_TRIPLE  = 8'h9F;
   localparam logic [7:0] OP_SIGNATURE  = 8'hAB;
   localparam logic [7:0] OP_PAIR       = 8'h90;
   localparam logic [7:0] OP_QUAD_ID    = 8'hAF;
   localparam logic [5:0] OPCODE_CLKS_SINGLE = 6'h08;
   localparam logic [5:0] OPCODE_CLKS_QUAD   = 6'h02;
   localparam logic [5:0] PAIR_PREAMBLE_BITS = 6'h18;
   localparam logic [5:0] REG_WRITE_ONE_BYTE = 6'h08;
   localparam logic [5:0] REG_WRITE_TWO_BYTE = 6'h10;

   // ==========================================================
   // Status register fields and reset values
   localparam int SR_BUSY   = 0;
   localparam int SR_WEL    = 1;
   localparam int SR_BP_LSB = 2;
   localparam int SR_QE     = 6;
   localparam int SR_REGISTER_WRITE_DISABLE_BIT   = 7;
   localparam logic [3:0] BP_RESET     = 4'h0;
   localparam logic [7:0] CONFIG_RESET = 8'h00;

   typedef enum logic [3:0] {
      CMD_NONE       = 4'h0,
      CMD_ID_TRIPLE  = 4'h1,
      CMD_SIGNATURE  = 4'h2,
      CMD_PAIR       = 4'h3,
      CMD_QUAD_ID    = 4'h4,
      CMD_STATUS     = 4'h5,
      CMD_CONFIG     = 4'h6,
      CMD_REG_WRITE  = 4'h7,
      CMD_WR_ENABLE  = 4'h8
   } cmd_e;

   typedef enum logic [3:0] {
      ST_STANDBY = 4'b0001,
      ST_SLEEP   = 4'b0010,
      ST_WAKING  = 4'b0100,
      ST_WRITING = 4'b1000
   } power_e;

   // Captured frame, stable while chip select is high
   typedef struct packed {
      cmd_e        cmd;
      logic [15:0] data;
      logic [5:0]  data_bits;
      logic        sig_done;
   } frame_s;

   // Device state seen by the link side
   typedef struct packed {
      logic       busy;
      logic       asleep;
      logic       quad;
      logic [7:0] status;
      logic [7:0] cfg;
   } mode_s;

endpackage : flash_cmd_pkg

`default_nettype wire

// file: logic/flash_id_status_cmd_unit.sv
`default_nettype none

module flash_id_status_cmd_unit #(
   parameter logic [7:0] MAKER_CODE       = 8'h5A,  // Arbitrary identity value
   parameter logic [7:0] MEMORY_TYPE      = 8'h11,  // Arbitrary identity value
   parameter logic [7:0] DENSITY_CODE     = 8'h22,  // Arbitrary identity value
   parameter logic [7:0] SIGNATURE_CODE   = 8'h22,  // Arbitrary identity value
   parameter logic [7:0] OP_STATUS_READ   = 8'h05,
   parameter logic [7:0] OP_CONFIG_READ   = 8'h15,
   parameter logic [7:0] OP_REG_WRITE     = 8'h01,
   parameter logic [7:0] OP_WRITE_ENABLE  = 8'h06,
   parameter int         REG_WRITE_CYCLES = flash_cmd_pkg::REG_WRITE_CYCLES
) (
   input  wire logic        mclk_i,
   input  wire logic        sys_rst_i,
   input  wire logic        sclk_i,
   input  wire logic        cs_n_i,
   input  wire logic [3:0]  sio_i,
   output logic      [3:0]  sio_o,
   output logic      [3:0]  sio_oe_o,
   input  wire logic        reset_pin_n_i,
   input  wire logic        quad_mode_i,
   input  wire logic        array_busy_i,
   input  wire logic        sleep_req_i,
   output logic      [7:0]  status_o,
   output logic      [7:0]  config_o,
   output logic             deep_sleep_o,
   output logic             hw_protect_o
);
   import flash_cmd_pkg::*;

   localparam int TIMER_W = 24;

   // ==========================================================
   // Shared helpers

   // Opcode to command, gated by the device state
   function automatic cmd_e decode(input logic [7:0] op, input mode_s m);
      cmd_e c;
      c = CMD_NONE;
      if (op == OP_ID_TRIPLE)         c = CMD_ID_TRIPLE;
      else if (op == OP_SIGNATURE)    c = CMD_SIGNATURE;
      else if (op == OP_PAIR)         c = CMD_PAIR;
      else if (op == OP_QUAD_ID)      c = CMD_QUAD_ID;
      else if (op == OP_STATUS_READ)  c = CMD_STATUS;
      else if (op == OP_CONFIG_READ)  c = CMD_CONFIG;
      else if (op == OP_REG_WRITE)    c = CMD_REG_WRITE;
      else if (op == OP_WRITE_ENABLE) c = CMD_WR_ENABLE;
      // Asleep: only the wake/signature opcode is heard
      if (m.asleep && c != CMD_SIGNATURE) c = CMD_NONE;
      // Busy: only the two register reads are served
      if (m.busy && c != CMD_STATUS && c != CMD_CONFIG) c = CMD_NONE;
      return c;
   endfunction : decode

   // Byte presented at a given position of the read stream
   function automatic logic [7:0] out_byte(input cmd_e c, input logic [1:0] idx,
                                           input logic swap, input mode_s m);
      logic [7:0] b;
      b = 8'h00;
      case (c)
         CMD_ID_TRIPLE, CMD_QUAD_ID: begin
            b = (idx == 2'h0) ? MAKER_CODE :
                (idx == 2'h1) ? MEMORY_TYPE : DENSITY_CODE;
         end
         CMD_SIGNATURE: b = SIGNATURE_CODE;
         CMD_PAIR:      b = (idx[0] ^ swap) ? SIGNATURE_CODE : MAKER_CODE;
         CMD_STATUS:    b = m.status;
         CMD_CONFIG:    b = m.cfg;
         default:       b = 8'h00;
      endcase
      return b;
   endfunction : out_byte

   // Bytes in one repetition of the stream
   function automatic logic [1:0] byte_period(input cmd_e c);
      logic [1:0] p;
      p = 2'h1;
      if (c == CMD_ID_TRIPLE || c == CMD_QUAD_ID) p = 2'h3;
      else if (c == CMD_PAIR) p = 2'h2;
      return p;
   endfunction : byte_period

   // ==========================================================
   // Link side, clocked by the serial clock

   mode_s       mode_now;
   mode_s       mode_meta;
   mode_s       mode_link;
   frame_s      frame;
   logic        frame_tog;
   logic        frame_clr;
   logic [7:0]  op_sr;
   logic [7:0]  next_op;
   logic [15:0] next_data;
   logic [5:0]  next_bits;
   logic [5:0]  op_len;
   logic [5:0]  cnt;
   cmd_e        next_cmd;
   logic        out_on;
   logic [2:0]  bit_idx;
   logic [1:0]  byte_idx;
   logic        pair_swap;
   logic        bit_last;
   logic [7:0]  cur_byte;
   logic [3:0]  so_data;
   logic [3:0]  so_oe;
   logic        data_phase;

   // Chip select high clears the clock count and read stream position without needing a clock edge
   assign frame_clr = cs_n_i | sys_rst_i;

   // Device state into the link domain; slow-moving between frames
   always_ff @(posedge sclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         mode_meta <= '0;
         mode_link <= '0;
      end else begin
         mode_meta <= mode_now;
         mode_link <= mode_meta;
      end
   end

   // Lane use: quad takes all four, single only lane 0
   assign op_len    = mode_link.quad ? OPCODE_CLKS_QUAD : OPCODE_CLKS_SINGLE;
   assign next_op   = mode_link.quad ? {op_sr[3:0], sio_i} : {op_sr[6:0], sio_i[0]};
   assign next_data = mode_link.quad ? {frame.data[11:0], sio_i}
                                     : {frame.data[14:0], sio_i[0]};
   assign next_bits = mode_link.quad ? frame.data_bits + 6'h04 : frame.data_bits + 6'h01;
   assign next_cmd  = decode(next_op, mode_link);
   assign bit_last  = mode_link.quad ? (bit_idx == 3'h1) : (bit_idx == 3'h7);
   assign cur_byte  = out_byte(frame.cmd, byte_idx, pair_swap, mode_link);
   assign data_phase = (cnt >= op_len) &&
                       (frame.cmd == CMD_REG_WRITE || frame.cmd == CMD_PAIR);

   // Frame capture: survives chip select rise for the system side
   always_ff @(posedge sclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         frame     <= '0;
         frame_tog <= 1'b0;
         op_sr     <= 8'h00;
      end else begin
         op_sr <= next_op;
         if (cnt == 6'h00) begin
            frame_tog       <= ~frame_tog;
            frame.cmd       <= CMD_NONE;
            frame.data      <= 16'h0000;
            frame.data_bits <= 6'h00;
            frame.sig_done  <= 1'b0;
         end else if (cnt == op_len - 6'h01) begin
            frame.cmd <= next_cmd;
         end else if (data_phase && frame.data_bits < 6'h3C) begin
            frame.data      <= next_data;
            frame.data_bits <= next_bits;
         end
         // One full signature byte makes it a signature read, not a bare wake
         if (out_on && bit_last && frame.cmd == CMD_SIGNATURE) begin
            frame.sig_done <= 1'b1;
         end
      end
   end

   // Clock count and read stream position, cleared by chip select
   always_ff @(posedge sclk_i or posedge frame_clr) begin
      if (frame_clr) begin
         cnt       <= 6'h00;
         out_on    <= 1'b0;
         bit_idx   <= 3'h0;
         byte_idx  <= 2'h0;
         pair_swap <= 1'b0;
      end else begin
         if (cnt != 6'h3F) cnt <= cnt + 6'h01;
         if (!out_on) begin
            if (cnt == op_len - 6'h01 && next_cmd != CMD_NONE && next_cmd != CMD_PAIR
                && next_cmd != CMD_REG_WRITE && next_cmd != CMD_WR_ENABLE) begin
               out_on <= 1'b1;
            end
            if (data_phase && frame.cmd == CMD_PAIR && next_bits == PAIR_PREAMBLE_BITS) begin
               out_on    <= 1'b1;
               pair_swap <= next_data[0];
            end
         end else if (bit_last) begin
            bit_idx  <= 3'h0;
            byte_idx <= (byte_idx == byte_period(frame.cmd) - 2'h1) ? 2'h0
                                                                    : byte_idx + 2'h1;
         end else begin
            bit_idx <= bit_idx + 3'h1;
         end
      end
   end

   // Data launched on the falling edge, MSB first
   always_ff @(negedge sclk_i or posedge frame_clr) begin
      if (frame_clr) begin
         so_data <= 4'h0;
         so_oe   <= 4'h0;
      end else if (out_on && mode_link.quad) begin
         so_data <= (bit_idx == 3'h0) ? cur_byte[7:4] : cur_byte[3:0];
         so_oe   <= 4'hF;
      end else if (out_on) begin
         so_data <= {2'b00, cur_byte[3'h7 - bit_idx], 1'b0};
         so_oe   <= 4'h2;
      end else begin
         so_data <= 4'h0;
         so_oe   <= 4'h0;
      end
   end

   assign sio_o    = so_data;
   assign sio_oe_o = so_oe;

   // ==========================================================
   // System side, clocked by mclk

   // Pins and the frame toggle: three stages, change taken when last two agree
   logic [3:0] sync1;
   logic [3:0] sync2;
   logic [3:0] sync3;
   logic [3:0] filt;
   logic       cs_prev;
   logic       tog_seen;
   logic       cs_rise;
   logic       act;
   logic       cs_hi;
   logic       tog_s;
   logic       wp_s;
   logic       rst_pin_s;

   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         sync1 <= 4'hE;
         sync2 <= 4'hE;
         sync3 <= 4'hE;
         filt  <= 4'hE;
      end else begin
         sync1 <= {cs_n_i, sio_i[2], reset_pin_n_i, frame_tog};
         sync2 <= sync1;
         sync3 <= sync2;
         for (int i = 0; i < 4; i++) begin
            if (sync2[i] == sync3[i]) filt[i] <= sync3[i];
         end
      end
   end

   assign cs_hi     = filt[3];
   assign wp_s      = filt[2];
   assign rst_pin_s = filt[1];
   assign tog_s     = filt[0];

   // Act once per clocked frame, after chip select is back high
   assign cs_rise = cs_hi & ~cs_prev;
   assign act     = cs_rise & (tog_s != tog_seen);

   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         cs_prev  <= 1'b1;
         tog_seen <= 1'b0;
      end else begin
         cs_prev <= cs_hi;
         if (act) tog_seen <= tog_s;
      end
   end

   // Power and write-cycle sequencer
   power_e             state;
   logic [TIMER_W-1:0] timer;
   logic [3:0]         bp;
   logic               qe;
   logic               register_write_disable_bit;
   logic               write_enable_latch;
   logic [7:0]         cfg;
   logic [15:0]        pend_data;
   logic               pend_two;
   logic               hardware_protected_mode;
   logic               busy_flag;
   logic               wr_ok;
   logic               bits_ok;

   // Protected mode only in single-lane operation with quad enable clear
   assign hardware_protected_mode       = register_write_disable_bit & ~wp_s & ~qe & ~quad_mode_i;
   assign busy_flag = (state == ST_WRITING) | array_busy_i;
   assign bits_ok   = (frame.data_bits == REG_WRITE_ONE_BYTE) ||
                      (frame.data_bits == REG_WRITE_TWO_BYTE);
   assign wr_ok     = write_enable_latch & ~hardware_protected_mode & bits_ok & ~array_busy_i & (state == ST_STANDBY);

   assign mode_now.busy   = busy_flag;
   assign mode_now.asleep = (state == ST_SLEEP) | (state == ST_WAKING);
   assign mode_now.quad   = quad_mode_i;
   assign mode_now.status = {register_write_disable_bit, qe, bp, write_enable_latch, busy_flag};
   assign mode_now.cfg    = cfg;

   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         state     <= ST_STANDBY;
         timer     <= '0;
         pend_data <= 16'h0000;
         pend_two  <= 1'b0;
      end else begin
         case (state)
            ST_STANDBY: begin
               if (act && frame.cmd == CMD_REG_WRITE && wr_ok) begin
                  state     <= ST_WRITING;
                  timer     <= TIMER_W'(REG_WRITE_CYCLES - 1);
                  pend_data <= frame.data;
                  pend_two  <= (frame.data_bits == REG_WRITE_TWO_BYTE);
               end else if (sleep_req_i) begin
                  state <= ST_SLEEP;
               end
            end
            ST_SLEEP: begin
               if (!rst_pin_s) begin
                  state <= ST_STANDBY;
               end else if (act && frame.cmd == CMD_SIGNATURE && !array_busy_i) begin
                  state <= ST_WAKING;
                  timer <= frame.sig_done ? TIMER_W'(WAKE_SECOND_CYCLES - 1)
                                          : TIMER_W'(WAKE_FIRST_CYCLES - 1);
               end
            end
            ST_WAKING: begin
               // Host holds chip select high meanwhile
               if (!rst_pin_s || timer == '0) state <= ST_STANDBY;
               else timer <= timer - TIMER_W'(1);
            end
            ST_WRITING: begin
               if (timer == '0) state <= ST_STANDBY;
               else timer <= timer - TIMER_W'(1);
            end
            default: state <= ST_STANDBY;
         endcase
      end
   end

   // Register contents; latch and busy never written from data
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         bp   <= BP_RESET;
         qe   <= 1'b0;
         register_write_disable_bit <= 1'b0;
         cfg  <= CONFIG_RESET;
      end else if (state == ST_WRITING && timer == '0) begin
         register_write_disable_bit <= pend_two ? pend_data[8 + SR_REGISTER_WRITE_DISABLE_BIT] : pend_data[SR_REGISTER_WRITE_DISABLE_BIT];
         qe   <= pend_two ? pend_data[8 + SR_QE] : pend_data[SR_QE];
         bp   <= pend_two ? pend_data[8 + SR_BP_LSB +: 4] : pend_data[SR_BP_LSB +: 4];
         if (pend_two) cfg <= pend_data[7:0];
      end
   end

   // Write-enable latch: set by command, cleared on write completion or pin
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         write_enable_latch <= 1'b0;
      end else if (!rst_pin_s || (state == ST_WRITING && timer == '0)) begin
         write_enable_latch <= 1'b0;
      end else if (act && frame.cmd == CMD_WR_ENABLE && state == ST_STANDBY
                   && !array_busy_i) begin
         write_enable_latch <= 1'b1;
      end
   end

   // Registered status outputs
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         status_o     <= 8'h00;
         config_o     <= CONFIG_RESET;
         deep_sleep_o <= 1'b0;
         hw_protect_o <= 1'b0;
      end else begin
         status_o     <= mode_now.status;
         config_o     <= cfg;
         deep_sleep_o <= mode_now.asleep;
         hw_protect_o <= hardware_protected_mode;
      end
   end

endmodule : flash_id_status_cmd_unit

`default_nettype wire

// file: dv/flash_cmd_properties.sv
`default_nettype none
module flash_cmd_properties (
   input wire logic       mclk_i,
   input wire logic       sys_rst_i,
   input wire logic       cs_n_i,
   input wire logic       reset_pin_n_i,
   input wire logic       array_busy_i,
   input wire logic [3:0] sio_oe_o,
   input wire logic [7:0] status_o,
   input wire logic       deep_sleep_o,
   input wire logic       hw_protect_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==========
   // Status and lane checks, system domain
   default clocking @(posedge mclk_i); endclocking
   default disable iff (sys_rst_i);
   // Array busy also shows as busy, so only write cycles count here
   sequence cycle_start_s;
      $rose(status_o[0]) && !array_busy_i;
   endsequence
   // End of array busy is not a write cycle end
   sequence cycle_end_s;
      $fell(status_o[0]) && !$past(array_busy_i, 2);
   endsequence
   idle_float_a: assert property (cs_n_i [*2] |-> sio_oe_o == 4'h0)
      else $error("lanes driven while deselected");
   oe_legal_a: assert property (sio_oe_o inside {4'h0, 4'h2, 4'hF})
      else $error("illegal lane enable pattern");
   write_gate_a: assert property (cycle_start_s |-> $past(status_o[1]))
      else $error("write cycle started without latch");
   busy_hold_a: assert property (cycle_start_s |-> status_o[0] [*8])
      else $error("write cycle too short");
   latch_clear_a: assert property (cycle_end_s |-> !status_o[1])
      else $error("latch left set after write cycle");
   bits_at_end_a: assert property ($changed(status_o[7:2]) |-> cycle_end_s)
      else $error("protect bits changed outside cycle end");
   protect_src_a: assert property (hw_protect_o |-> status_o[7] && !status_o[6])
      else $error("protected mode without write disable");
   pin_wake_a: assert property (!reset_pin_n_i [*8] |-> !deep_sleep_o && !status_o[1])
      else $error("reset pin did not wake or clear latch");
endmodule : flash_cmd_properties
`default_nettype wire

// file: dv/flash_host_model.sv
`default_nettype none
module flash_host_model (
   input  wire logic [3:0] line_i,
   input  wire logic       quad_i,
   output logic            sclk_o,
   output logic            cs_n_o,
   output logic      [3:0] drv_o,
   output logic      [3:0] drv_oe_o
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int HALF = 24;
   // ==========
   // Idle: clock parked low, lanes released
   initial begin
      sclk_o   = 1'b0;
      cs_n_o   = 1'b1;
      drv_o    = 4'h0;
      drv_oe_o = 4'h0;
   end
   // One frame: opcode, write bits, then read clocks; clock only inside
   task automatic xfer(input logic [7:0] op, input logic [23:0] wd, input int wn,
                       input int rn, output logic [47:0] rd);
      int          opn;
      logic [31:0] tx;
      opn      = quad_i ? 2 : 8;
      tx       = {op, 24'(wd << (24 - wn))};
      rd       = '0;
      cs_n_o   = 1'b0;
      drv_oe_o = quad_i ? 4'hF : 4'h9;
      for (int i = 0; i < opn + wn + rn; i++) begin
         if (quad_i) begin
            drv_o = tx[31:28];
            tx    = tx << 4;
         end else begin
            drv_o = {1'($urandom), 2'b00, tx[31]};
            tx    = tx << 1;
         end
         if (quad_i && i >= opn) drv_oe_o = 4'h0;
         #HALF sclk_o = 1'b1;
         if (i >= opn + wn) rd = quad_i ? {rd[43:0], line_i} : {rd[46:0], line_i[1]};
         #HALF sclk_o = 1'b0;
      end
      #HALF cs_n_o = 1'b1;
      drv_oe_o = 4'h0;
   endtask : xfer
endmodule : flash_host_model
`default_nettype wire

// file: dv/flash_id_status_cmd_unit_tb_top.sv
`default_nettype none
module flash_id_status_cmd_unit_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import flash_cmd_pkg::*;
   localparam logic [7:0] MK = 8'h3C; // Arbitrary identity value
   localparam logic [7:0] TY = 8'h4D; // Arbitrary identity value
   localparam logic [7:0] DN = 8'h6E; // Arbitrary identity value
   localparam logic [7:0] OP_SR = 8'h05, OP_CR = 8'h15, OP_WR = 8'h01, OP_WE = 8'h06;
   logic        mclk, rst, arr_busy, sleep_req, quad, wp, pin_n, oe_seen;
   logic        idle_t = 1'b0;
   logic        sclk, cs_n;
   logic [3:0]  line, hdrv, hdrv_oe, sio_o, sio_oe;
   logic [7:0]  status, cfg;
   logic        asleep, hardware_protected_mode;
   int          error_cnt, n_compared, cyc;
   // ==========
   // Lane resolution: undriven lanes toggle, lane 2 idles at protect level
   assign line = (sio_oe & sio_o) | (~sio_oe & hdrv_oe & hdrv)
               | (~sio_oe & ~hdrv_oe & {idle_t, wp, idle_t, idle_t});
   always @(posedge mclk) idle_t <= ~idle_t;
   always @(posedge sclk) if (sio_oe != 4'h0) oe_seen = 1'b1;
   flash_host_model u_flash_host_model (.line_i(line), .quad_i(quad), .sclk_o(sclk),
      .cs_n_o(cs_n), .drv_o(hdrv), .drv_oe_o(hdrv_oe));
   flash_id_status_cmd_unit #(.MAKER_CODE(MK), .MEMORY_TYPE(TY), .DENSITY_CODE(DN),
      .SIGNATURE_CODE(DN), .OP_STATUS_READ(OP_SR), .OP_CONFIG_READ(OP_CR),
      .OP_REG_WRITE(OP_WR), .OP_WRITE_ENABLE(OP_WE), .REG_WRITE_CYCLES(200)
   ) u_flash_id_status_cmd_unit (.mclk_i(mclk), .sys_rst_i(rst), .sclk_i(sclk),
      .cs_n_i(cs_n), .sio_i(line), .sio_o(sio_o), .sio_oe_o(sio_oe),
      .reset_pin_n_i(pin_n), .quad_mode_i(quad), .array_busy_i(arr_busy),
      .sleep_req_i(sleep_req), .status_o(status), .config_o(cfg),
      .deep_sleep_o(asleep), .hw_protect_o(hardware_protected_mode));
   // ==========
   // Clock, timeout and shared tasks
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         finish_test();
      end
   end
   task automatic step(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : step
   task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
      n_compared++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   // Frame then the idle gap the design needs
   task automatic host(input logic [7:0] op, input logic [23:0] wd, input int wn,
                       input int rn, output logic [47:0] rd);
      oe_seen = 1'b0;
      u_flash_host_model.xfer(op, wd, wn, rn, rd);
      step(6);
   endtask : host
   function automatic logic [7:0] exp_stat(input logic [7:0] d);
      return {d[7:2], 2'b00};
   endfunction : exp_stat
   task automatic wait_idle();
      for (int n = 0; n < 400 && status[0] !== 1'b0; n++) step(1);
   endtask : wait_idle
   // Sleep, status probe, wake by shared opcode with optional signature read, time to standby
   task automatic nap(input int rn, input int lo, input string what);
      logic [47:0] rd;
      int          n;
      sleep_req = 1'b1;
      step(1);
      sleep_req = 1'b0;
      step(6);
      host(OP_SR, 24'h0, 0, 8, rd);
      check("read while asleep", {47'h0, oe_seen}, 48'h0);
      u_flash_host_model.xfer(OP_SIGNATURE, 24'h0, 0, rn, rd);
      if (rn > 0) check("sleep signature", rd, {32'h0, DN, DN});
      for (n = 0; n < 400 && asleep === 1'b1; n++) step(1);
      check(what, 48'(n >= lo && n <= lo + 8), 48'h1);
      step(4);
   endtask : nap
   task automatic finish_test();
      $display("mismatches %0d, comparisons %0d", error_cnt, n_compared);
      if (error_cnt == 0 && n_compared > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : finish_test
   // ==========
   // Main sequence
   initial begin
      logic [47:0] rd;
      logic [7:0]  d, c;
      {arr_busy, sleep_req, quad, oe_seen} = '0;
      {error_cnt, n_compared, cyc} = '0;
      {rst, wp, pin_n} = 3'b111;
      void'($urandom(32'h31392eca));
      step(8);
      rst = 1'b0;
      step(6);
      host(OP_SR, 24'h0, 0, 16, rd);
      check("status after reset", rd, 48'h0);
      host(OP_ID_TRIPLE, 24'h0, 0, 48, rd);
      check("triple id", rd, {MK, TY, DN, MK, TY, DN});
      host(OP_ID_TRIPLE, 24'h0, 0, 5, rd);
      check("cut id", rd, {43'h0, MK[7:3]});
      check("lanes freed", {44'h0, sio_oe}, 48'h0);
      for (int a = 0; a < 2; a++) begin
         host(OP_PAIR, {16'($urandom), 8'(a)}, 24, 32, rd);
         check("pair", rd, a ? {16'h0, DN, MK, DN, MK} : {16'h0, MK, DN, MK, DN});
      end
      host(OP_SIGNATURE, 24'h0, 0, 16, rd);
      check("signature", rd, {32'h0, DN, DN});
      check("awake after signature", {47'h0, asleep}, 48'h0);
      quad = 1'b1;
      host(8'h00, 24'h0, 0, 0, rd);
      host(OP_QUAD_ID, 24'h0, 0, 12, rd);
      check("quad id", rd, {MK, TY, DN, MK, TY, DN});
      quad = 1'b0;
      host(8'h00, 24'h0, 0, 0, rd);
      host(OP_WE, 24'h0, 0, 0, rd);
      check("latch set", {40'h0, status}, 48'h02);
      d = 8'h3C & 8'($urandom);
      c = 8'($urandom);
      host(OP_WR, {8'h00, d, c}, 16, 0, rd);
      host(OP_SR, 24'h0, 0, 8, rd);
      check("status in cycle", rd, 48'h03);
      host(OP_CR, 24'h0, 0, 8, rd);
      check("config in cycle", rd, {40'h0, CONFIG_RESET});
      wait_idle();
      check("status written", {32'h0, status, cfg}, {32'h0, exp_stat(d), c});
      d = 8'h80 | (8'h3C & 8'($urandom));
      host(OP_WE, 24'h0, 0, 0, rd);
      host(OP_WR, {16'h0, d}, 8, 0, rd);
      wait_idle();
      check("one byte write", {32'h0, status, cfg}, {32'h0, exp_stat(d), c});
      host(OP_WR, {16'h0, ~d}, 8, 0, rd);
      host(OP_WE, 24'h0, 0, 0, rd);
      host(OP_WR, {12'h0, ~d, 4'h0}, 12, 0, rd);
      check("refused writes", {45'h0, status[7:6], status[0]}, {45'h0, d[7:6], 1'b0});
      wp = 1'b0;
      step(8);
      check("protected mode", {47'h0, hardware_protected_mode}, 48'h1);
      host(OP_WR, {16'h0, ~d}, 8, 0, rd);
      // Busy bit too: an accepted write would not move the bits for a long while
      check("refused in protect", {40'h0, status[7:2], 1'b0, status[0]},
            {40'h0, exp_stat(d)});
      wp = 1'b1;
      nap(0, WAKE_FIRST_CYCLES, "first wake delay");
      nap(16, WAKE_SECOND_CYCLES, "second wake delay");
      sleep_req = 1'b1;
      step(1);
      sleep_req = 1'b0;
      step(4);
      pin_n = 1'b0;
      step(10);
      pin_n = 1'b1;
      check("pin wake", {46'h0, asleep, status[1]}, 48'h0);
      step(6);
      arr_busy = 1'b1;
      step(6);
      host(OP_ID_TRIPLE, 24'h0, 0, 24, rd);
      check("id refused while busy", {47'h0, oe_seen}, 48'h0);
      host(OP_SR, 24'h0, 0, 8, rd);
      check("status while busy", {42'h0, rd[7:2]}, {42'h0, d[7:2]});
      arr_busy = 1'b0;
      step(10);
      finish_test();
   end
endmodule : flash_id_status_cmd_unit_tb_top
bind flash_id_status_cmd_unit flash_cmd_properties u_flash_cmd_properties (
   .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .cs_n_i(cs_n_i), .reset_pin_n_i(reset_pin_n_i),
   .array_busy_i(array_busy_i), .sio_oe_o(sio_oe_o), .status_o(status_o),
   .deep_sleep_o(deep_sleep_o), .hw_protect_o(hw_protect_o));
`default_nettype wire
